// [design/mdt_top.sv]
// Purpose: parses and classifies monolithic descriptor words
// Assumes: words arrive in order from word 0, same clock as the core
// Notes: APB slave answers with no wait states
//
// Behaviour
// R1 - word 2 bit 31 tells whether the 16-byte extended block exists
// R2 - word 2 bits 29-24 count protocol words, at most 32
// R3 - word 2 bits 23-20 are packet-type error flags
// R4 - word 2 bits 19-16 are packet-type protocol flags
// R5 - finished transmit descriptor goes to tail if bit 14 clear, else head
// R6 - bits 13-12 pick the return manager, never changed by DMA
// R7 - bits 11-0 pick the return queue, not rewritten on receive
// R8 - alignment and extended words exist only with the present bit set
// R9 - alignment word is neither copied nor overwritten
// R10 - first extended word is timestamp; receive overwrite is configurable
// R11 - three software words copied on prefetch or infrastructure transfer
// R12 - protocol words follow the software words directly
// R13 - payload starts at word 0 data offset, overwritten on receive
// R14 - only payload follows system byte order
// R15 - word 0 bits 24-16 give payload offset 0 to 511
// R16 - protocol data at byte 32 with extended block, else byte 12
// R17 - word 0 bits 31-30 must equal 2
// R18 - word 2 fields latched together and presented decoded
`default_nettype none

module mdt_top #(
    parameter int AW = 12
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // descriptor words in
    input wire logic desc_valid_i,
    input wire logic desc_sop_i,
    input wire logic [31:0] desc_data_i,
    input wire logic rx_dir_i,
    // transmit completion
    input wire logic tx_done_i,
    // classified words out
    output logic out_valid_o,
    output logic [3:0] out_kind_o,
    output logic [14:0] out_index_o,
    output logic [31:0] out_data_o,
    output logic [31:0] out_ovr_mask_o,
    output logic out_copy_o,
    // decoded word 2
    output logic ext_present_o,
    output logic [5:0] ps_count_o,
    output logic [3:0] err_flags_o,
    output logic [3:0] ps_flags_o,
    // descriptor return
    output logic ret_valid_o,
    output logic ret_head_o,
    output logic [1:0] ret_qmgr_o,
    output logic [11:0] ret_qnum_o
);

    initial begin
        if (AW < 12) begin
            $error("mdt_top: AW too small for the register map");
        end
    end

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ************************************************************
    // word 2 decoder
    // ************************************************************
    mdt_w2_if w2 ();

    logic [14:0] idx;
    logic [14:0] cur_idx;

    assign cur_idx = desc_sop_i ? 15'h0000 : idx;
    assign w2.strobe = desc_valid_i && !desc_sop_i &&
                       (idx == mdt_pkg::IDX_W2);
    assign w2.word = desc_data_i;

    mdt_word2_dec u_dec (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .w2(w2)
    );

    // ************************************************************
    // registers
    // ************************************************************
    logic [1:0] ctrl;
    logic [2:0] status;
    logic [15:0] desc_count;
    logic apb_done;
    logic [2:0] ev_set;

    assign apb_done = psel_i && penable_i && pready_o;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= mdt_pkg::CTRL_RESET;
        end else if (apb_done && pwrite_i &&
                     paddr_i[11:0] == mdt_pkg::REG_CTRL) begin
            ctrl <= pwdata_i[1:0];
        end
    end

    // write one to clear, a new event wins
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            status <= 3'h0;
        end else if (apb_done && pwrite_i &&
                     paddr_i[11:0] == mdt_pkg::REG_STATUS) begin
            status <= (status & ~pwdata_i[2:0]) | ev_set;
        end else begin
            status <= status | ev_set;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= psel_i && !penable_i;
            if (psel_i && !penable_i) begin
                pslverr_o <= 1'b0;
                prdata_o <= 32'h0000_0000;
                case (paddr_i[11:0])
                    mdt_pkg::REG_CTRL: prdata_o <= {30'h0, ctrl};
                    mdt_pkg::REG_STATUS: prdata_o <= {29'h0, status};
                    mdt_pkg::REG_WORD2: prdata_o <= w2.raw;
                    mdt_pkg::REG_COUNT: prdata_o <= {16'h0, desc_count};
                    default: pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    // ************************************************************
    // descriptor walk
    // ************************************************************
    mdt_pkg::mdt_state_t state;
    logic [8:0] data_off;
    logic [15:0] pkt_len;
    logic [14:0] ps_start;
    logic [14:0] ps_end;
    logic [14:0] pay_start;
    logic [14:0] pay_end;
    logic [5:0] ps_eff;
    mdt_pkg::mdt_kind_t next_kind;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= mdt_pkg::ST_IDLE;
            idx <= 15'h0000;
        end else if (desc_valid_i) begin
            idx <= cur_idx + 15'h0001;
            state <= mdt_pkg::ST_BODY;
        end
    end

    // R15 offset and length
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            data_off <= 9'h000;
            pkt_len <= 16'h0000;
        end else if (desc_valid_i && desc_sop_i) begin
            data_off <= desc_data_i[mdt_pkg::W0_OFF_MSB:mdt_pkg::W0_OFF_LSB];
            pkt_len <= desc_data_i[mdt_pkg::W0_LEN_MSB:mdt_pkg::W0_LEN_LSB];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            desc_count <= 16'h0000;
        end else if (desc_valid_i && desc_sop_i) begin
            desc_count <= desc_count + 16'h0001;
        end
    end

    // R2 reserved counts clamp
    assign ps_eff = w2.ps_reserved ? mdt_pkg::PS_MAX : w2.ps_count;
    // R16 protocol start
    assign ps_start = w2.ext_present ? mdt_pkg::IDX_PS_EXT
                                     : mdt_pkg::IDX_PS_NOEXT;
    // R12 directly after
    assign ps_end = ps_start + {9'h000, ps_eff};
    assign pay_start = {8'h00, data_off[8:2]};
    assign pay_end = pay_start + {1'b0, pkt_len[15:2]}
                   + {14'h0000, |pkt_len[1:0]};

    always_comb begin
        next_kind = mdt_pkg::K_OTHER;
        if (desc_sop_i) begin
            next_kind = mdt_pkg::K_WORD0;
        end else if (idx == mdt_pkg::IDX_W1) begin
            next_kind = mdt_pkg::K_WORD1;
        end else if (idx == mdt_pkg::IDX_W2) begin
            next_kind = mdt_pkg::K_WORD2;
        // R8 extended words only when present
        end else if (w2.ext_present && idx <= mdt_pkg::IDX_SW_LAST) begin
            if (idx == mdt_pkg::IDX_ALIGN) begin
                next_kind = mdt_pkg::K_ALIGN;
            end else if (idx == mdt_pkg::IDX_TS) begin
                next_kind = mdt_pkg::K_TSTAMP;
            end else begin
                next_kind = mdt_pkg::K_SWINFO;
            end
        end else if (idx < ps_end) begin
            next_kind = mdt_pkg::K_PSWORD;
        // R13 payload from the data offset
        end else if (idx < pay_start) begin
            next_kind = mdt_pkg::K_NULL;
        end else if (idx < pay_end) begin
            next_kind = mdt_pkg::K_PAYLOAD;
        end
    end

    // ************************************************************
    // error events
    // ************************************************************
    always_comb begin
        ev_set = 3'h0;
        // R17 type check
        if (desc_valid_i && desc_sop_i &&
            desc_data_i[mdt_pkg::W0_TYPE_MSB:mdt_pkg::W0_TYPE_LSB] !=
            mdt_pkg::DESC_MONO) begin
            ev_set[mdt_pkg::STS_BAD_TYPE] = 1'b1;
        end
        // R2 reserved count, and payload start before protocol end
        if (desc_valid_i && idx == mdt_pkg::IDX_ALIGN && !desc_sop_i) begin
            ev_set[mdt_pkg::STS_BAD_PSCNT] = w2.ps_reserved;
            ev_set[mdt_pkg::STS_BAD_OFFSET] = (pay_start < ps_end);
        end
    end

    // ************************************************************
    // classified output
    // ************************************************************
    logic [31:0] swapped;
    logic is_pay;

    assign is_pay = (next_kind == mdt_pkg::K_PAYLOAD);

    // R14 byte order on payload only
    mdt_swap #(
        .WIDTH(32)
    ) u_swap (
        .swap_i(is_pay && ctrl[mdt_pkg::CTRL_BIG_END]),
        .data_i(desc_data_i),
        .data_o(swapped)
    );

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_o <= 1'b0;
            out_kind_o <= 4'h0;
            out_index_o <= 15'h0000;
            out_data_o <= 32'h0000_0000;
        end else begin
            out_valid_o <= desc_valid_i;
            if (desc_valid_i) begin
                out_kind_o <= next_kind;
                out_index_o <= cur_idx;
                out_data_o <= swapped;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            out_ovr_mask_o <= 32'h0000_0000;
            out_copy_o <= 1'b0;
        end else if (desc_valid_i) begin
            // R11 software words travel
            out_copy_o <= (next_kind == mdt_pkg::K_SWINFO);
            out_ovr_mask_o <= 32'h0000_0000;
            if (rx_dir_i) begin
                case (next_kind)
                    // R6 R7 return fields kept
                    mdt_pkg::K_WORD2: out_ovr_mask_o <= mdt_pkg::W2_RX_MASK;
                    // R9 scratch word untouched
                    mdt_pkg::K_ALIGN: out_ovr_mask_o <= 32'h0000_0000;
                    // R10 timestamp by control
                    mdt_pkg::K_TSTAMP:
                        out_ovr_mask_o <= {32{ctrl[mdt_pkg::CTRL_TS_OVR]}};
                    mdt_pkg::K_WORD0, mdt_pkg::K_WORD1, mdt_pkg::K_SWINFO,
                    mdt_pkg::K_PSWORD, mdt_pkg::K_PAYLOAD:
                        out_ovr_mask_o <= 32'hffff_ffff;
                    default: out_ovr_mask_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // decoded fields and return request
    // ************************************************************
    // R18 decoded outputs
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ext_present_o <= 1'b0;
            ps_count_o <= 6'h00;
            err_flags_o <= 4'h0;
            ps_flags_o <= 4'h0;
        end else begin
            ext_present_o <= w2.ext_present;
            ps_count_o <= w2.ps_count;
            err_flags_o <= w2.err_flags;
            ps_flags_o <= w2.ps_flags;
        end
    end

    // R5 head or tail push
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ret_valid_o <= 1'b0;
            ret_head_o <= 1'b0;
            ret_qmgr_o <= 2'h0;
            ret_qnum_o <= 12'h000;
        end else begin
            ret_valid_o <= tx_done_i;
            if (tx_done_i) begin
                ret_head_o <= w2.push_head;
                ret_qmgr_o <= w2.ret_qmgr;
                ret_qnum_o <= w2.ret_qnum;
            end
        end
    end

endmodule

`default_nettype wire

// [shared/mdt_pkg.sv]
// Purpose: constants and types for the monolithic descriptor tail parser
// Assumes: 32-bit descriptor words, APB register access
// Notes: word indexes count 32-bit words from the descriptor start
`default_nettype none

package mdt_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_WORD2 = 12'h008;
    localparam logic [11:0] REG_COUNT = 12'h00c;
    localparam int CTRL_TS_OVR = 0;
    localparam int CTRL_BIG_END = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int STS_BAD_TYPE = 0;
    localparam int STS_BAD_PSCNT = 1;
    localparam int STS_BAD_OFFSET = 2;

    // ************************************************************
    // word 0 and word 2 fields
    // ************************************************************
    localparam int W0_TYPE_MSB = 31;
    localparam int W0_TYPE_LSB = 30;
    localparam logic [1:0] DESC_MONO = 2'h2;
    localparam int W0_OFF_MSB = 24;
    localparam int W0_OFF_LSB = 16;
    localparam int W0_LEN_MSB = 15;
    localparam int W0_LEN_LSB = 0;
    localparam int W2_EXT_BIT = 31;
    localparam int W2_PSCNT_MSB = 29;
    localparam int W2_PSCNT_LSB = 24;
    localparam int W2_ERR_MSB = 23;
    localparam int W2_ERR_LSB = 20;
    localparam int W2_PSF_MSB = 19;
    localparam int W2_PSF_LSB = 16;
    localparam int W2_PUSH_BIT = 14;
    localparam int W2_QMGR_MSB = 13;
    localparam int W2_QMGR_LSB = 12;
    localparam int W2_QNUM_MSB = 11;
    localparam int W2_QNUM_LSB = 0;
    localparam logic [5:0] PS_MAX = 6'h20;
    // receive may rewrite only the upper half of word 2
    localparam logic [31:0] W2_RX_MASK = 32'hffff_0000;

    // ************************************************************
    // word positions
    // ************************************************************
    localparam logic [14:0] IDX_W1 = 15'h0001;
    localparam logic [14:0] IDX_W2 = 15'h0002;
    localparam logic [14:0] IDX_ALIGN = 15'h0003;
    localparam logic [14:0] IDX_TS = 15'h0004;
    localparam logic [14:0] IDX_SW_LAST = 15'h0007;
    localparam logic [14:0] IDX_PS_EXT = 15'h0008;
    localparam logic [14:0] IDX_PS_NOEXT = 15'h0003;

    typedef enum logic [3:0] {
        K_WORD0, K_WORD1, K_WORD2, K_ALIGN, K_TSTAMP, K_SWINFO,
        K_PSWORD, K_NULL, K_PAYLOAD, K_OTHER
    } mdt_kind_t;

    typedef enum logic [1:0] {ST_IDLE, ST_BODY, ST_DONE} mdt_state_t;

endpackage

`default_nettype wire

// [shared/mdt_w2_if.sv]
// Purpose: carries word 2 capture and its decoded fields
// Assumes: one clock domain
// Notes: fields hold until the next strobe
`default_nettype none

interface mdt_w2_if;
    logic strobe;
    logic [31:0] word;
    logic ext_present;
    logic [5:0] ps_count;
    logic ps_reserved;
    logic [3:0] err_flags;
    logic [3:0] ps_flags;
    logic push_head;
    logic [1:0] ret_qmgr;
    logic [11:0] ret_qnum;
    logic [31:0] raw;

    modport dec (
        input strobe, word,
        output ext_present, ps_count, ps_reserved, err_flags, ps_flags,
        output push_head, ret_qmgr, ret_qnum, raw
    );
    modport use_side (
        output strobe, word,
        input ext_present, ps_count, ps_reserved, err_flags, ps_flags,
        input push_head, ret_qmgr, ret_qnum, raw
    );
endinterface

`default_nettype wire

// [design/mdt_word2_dec.sv]
// Purpose: latches descriptor word 2 and splits it into fields
// Assumes: strobe is a single-cycle pulse on the same clock
// Notes: all fields change together
`default_nettype none

module mdt_word2_dec (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // word 2 carrier
    mdt_w2_if.dec w2
);

    // R18 latch together
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w2.raw <= 32'h0000_0000;
        end else if (w2.strobe) begin
            w2.raw <= w2.word;
        end
    end

    // R1 extended block flag
    assign w2.ext_present = w2.raw[mdt_pkg::W2_EXT_BIT];
    // R2 protocol word count
    assign w2.ps_count =
        w2.raw[mdt_pkg::W2_PSCNT_MSB:mdt_pkg::W2_PSCNT_LSB];
    assign w2.ps_reserved = (w2.ps_count > mdt_pkg::PS_MAX);
    // R3 error flags
    assign w2.err_flags = w2.raw[mdt_pkg::W2_ERR_MSB:mdt_pkg::W2_ERR_LSB];
    // R4 protocol flags
    assign w2.ps_flags = w2.raw[mdt_pkg::W2_PSF_MSB:mdt_pkg::W2_PSF_LSB];
    // R5 push policy
    assign w2.push_head = w2.raw[mdt_pkg::W2_PUSH_BIT];
    // R6 return manager
    assign w2.ret_qmgr =
        w2.raw[mdt_pkg::W2_QMGR_MSB:mdt_pkg::W2_QMGR_LSB];
    // R7 return queue
    assign w2.ret_qnum =
        w2.raw[mdt_pkg::W2_QNUM_MSB:mdt_pkg::W2_QNUM_LSB];

endmodule

`default_nettype wire

// [design/mdt_swap.sv]
// Purpose: optional byte-order reversal of one data word
// Assumes: width is a whole number of bytes
// Notes: purely combinational
`default_nettype none

module mdt_swap #(
    parameter int WIDTH = 32
) (
    // control
    input wire logic swap_i,
    // data
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] data_o
);

    localparam int NB = WIDTH / 8;

    initial begin
        if (WIDTH % 8 != 0 || WIDTH < 8) begin
            $error("mdt_swap: WIDTH must be a multiple of 8");
        end
    end

    for (genvar b = 0; b < NB; b++) begin : g_byte
        assign data_o[8*b +: 8] =
            swap_i ? data_i[8*(NB-1-b) +: 8] : data_i[8*b +: 8];
    end

endmodule

`default_nettype wire

// [test/mdt_properties.sv]
// Purpose: port checks for the descriptor tail parser
// Assumes: bound onto mdt_top, one clock domain
// Notes: w2_q shadows the last word 2 seen on the output stream
`default_nettype none
module mdt_properties (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // inputs watched
    input wire logic [31:0] desc_data_i,
    input wire logic tx_done_i,
    // outputs watched
    input wire logic out_valid_o,
    input wire logic [3:0] out_kind_o,
    input wire logic [14:0] out_index_o,
    input wire logic [31:0] out_data_o,
    input wire logic [31:0] out_ovr_mask_o,
    input wire logic out_copy_o,
    input wire logic ext_present_o,
    input wire logic ret_valid_o,
    input wire logic ret_head_o,
    input wire logic [1:0] ret_qmgr_o,
    input wire logic [11:0] ret_qnum_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic w2_seen;
    logic [31:0] w2_q;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    assign w2_seen = out_valid_o && out_kind_o == mdt_pkg::K_WORD2;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w2_q <= 32'h0;
        end else if (w2_seen) begin
            w2_q <= out_data_o;
        end
    end
    // ****************************************
    // checks
    // ****************************************
    ext_latch_a: assert property (
        w2_seen |=> ext_present_o == $past(out_data_o[31]))
        else $error("present flag not latched");
    ret_head_a: assert property (
        tx_done_i |=> ret_valid_o && ret_head_o == w2_q[14])
        else $error("return push policy wrong");
    ret_queue_a: assert property (
        ret_valid_o |-> ret_qmgr_o == w2_q[13:12] &&
        ret_qnum_o == w2_q[11:0])
        else $error("return queue wrong");
    w2_keep_a: assert property (
        w2_seen |-> out_ovr_mask_o[15:0] == 16'h0)
        else $error("word 2 low half writable");
    align_word_a: assert property (
        out_valid_o && out_index_o == 15'h3 && w2_q[31]
        |-> out_kind_o == mdt_pkg::K_ALIGN && out_ovr_mask_o == 32'h0)
        else $error("alignment word mishandled");
    swinfo_copy_a: assert property (
        out_valid_o && out_kind_o == mdt_pkg::K_SWINFO
        |-> out_copy_o && out_index_o inside {15'h5, 15'h6, 15'h7})
        else $error("software word not copied");
    ps_place_a: assert property (
        out_valid_o && out_kind_o == mdt_pkg::K_PSWORD
        |-> out_index_o >= (w2_q[31] ? 15'h8 : 15'h3))
        else $error("protocol word misplaced");
    data_pass_a: assert property (
        out_valid_o && out_kind_o != mdt_pkg::K_PAYLOAD
        |-> out_data_o == $past(desc_data_i))
        else $error("non-payload word altered");
endmodule
bind mdt_top mdt_properties i_props (.*);
`default_nettype wire

// [test/mdt_desc_src.sv]
// Purpose: host-side source of monolithic descriptor words
// Assumes: one word per cycle once started
// Notes: idle data line inverts every bit on each idle cycle
`default_nettype none
module mdt_desc_src (
    // clock and control
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [31:0] w0_i,
    input wire logic [31:0] w2_i,
    input wire logic [4:0] nwords_i,
    output logic busy_o,
    // descriptor stream
    output logic desc_valid_o,
    output logic desc_sop_o,
    output logic [31:0] desc_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] idx = 5'h0;
    initial begin
        busy_o = 1'b0;
        desc_valid_o = 1'b0;
        desc_sop_o = 1'b0;
        desc_data_o = 32'h0;
    end
    always @(posedge clk_i) begin
        if (start_i) begin
            idx <= 5'h0;
            busy_o <= 1'b1;
        end else if (busy_o) begin
            desc_valid_o <= 1'b1;
            desc_sop_o <= idx == 5'h0;
            case (idx)
                5'h0: desc_data_o <= w0_i;
                5'h2: desc_data_o <= w2_i;
                default: desc_data_o <= {16'hd000, 11'h0, idx};
            endcase
            idx <= idx + 5'h1;
            busy_o <= idx + 5'h1 < nwords_i;
        end else begin
            desc_valid_o <= 1'b0;
            desc_sop_o <= 1'b0;
            desc_data_o <= ~desc_data_o;
        end
    end
endmodule
`default_nettype wire

// [test/tb.sv]
// Purpose: self-checking bench for the descriptor tail parser
// Assumes: descriptors come from mdt_desc_src
// Notes: kind, data and mask of each word are kept by index
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0, reset_n_i = 1'b0, psel_i = 1'b0;
    logic penable_i = 1'b0, pwrite_i = 1'b0, rx_dir_i = 1'b0;
    logic tx_done_i = 1'b0, src_go = 1'b0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0, src_w0 = 32'h0, src_w2 = 32'h0;
    logic [4:0] src_n = 5'h0;
    logic [31:0] prdata_o, desc_data_i, out_data_o, out_ovr_mask_o, rd_v;
    logic pready_o, pslverr_o, desc_valid_i, desc_sop_i, out_valid_o, er_v;
    logic out_copy_o, ext_present_o, ret_valid_o, ret_head_o, src_busy;
    logic [3:0] out_kind_o, err_flags_o, ps_flags_o;
    logic [14:0] out_index_o;
    logic [5:0] ps_count_o;
    logic [1:0] ret_qmgr_o;
    logic [11:0] ret_qnum_o;
    logic [3:0] kinds [16];
    logic [31:0] dats [16];
    logic [31:0] masks [16];
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    mdt_top i_dut (.*);
    mdt_desc_src i_src (
        .clk_i(core_clk_i), .start_i(src_go), .w0_i(src_w0), .w2_i(src_w2),
        .nwords_i(src_n), .busy_o(src_busy), .desc_valid_o(desc_valid_i),
        .desc_sop_o(desc_sop_i), .desc_data_o(desc_data_i)
    );
    always #2 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc++;
        if (out_valid_o === 1'b1) begin
            kinds[out_index_o[3:0]] <= out_kind_o;
            dats[out_index_o[3:0]] <= out_data_o;
            masks[out_index_o[3:0]] <= out_ovr_mask_o;
        end
        if (cyc == 4000) begin
            err_total++;
            summarize();
        end
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        int k = 0;
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        chk("pready", {31'h0, pready_o}, 32'h1);
        rd_v = prdata_o;
        er_v = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("rdata", rd_v, e);
    endtask
    task automatic run(input logic [31:0] w0, w2, input logic [4:0] n);
        int k = 0;
        foreach (kinds[i]) kinds[i] = 4'hf;
        src_w0 <= w0;
        src_w2 <= w2;
        src_n <= n;
        src_go <= 1'b1;
        @(posedge core_clk_i);
        src_go <= 1'b0;
        @(posedge core_clk_i);
        while (src_busy === 1'b1 && k < 40) begin
            @(posedge core_clk_i);
            k++;
        end
        repeat (3) @(posedge core_clk_i);
    endtask
    task automatic kchk(input logic [47:0] ek, input int n);
        for (int i = 0; i < n; i++) begin
            chk("kind", {28'h0, kinds[i]}, {28'h0, ek[4*i +: 4]});
        end
    endtask
    task automatic ret(input logic [31:0] e);
        tx_done_i <= 1'b1;
        @(posedge core_clk_i);
        tx_done_i <= 1'b0;
        @(posedge core_clk_i);
        chk("ret valid", {31'h0, ret_valid_o}, 32'h1);
        chk("ret", {17'h0, ret_head_o, ret_qmgr_o, ret_qnum_o}, e);
    endtask
    function automatic logic [31:0] dec();
        return {17'h0, ext_present_o, ps_count_o, err_flags_o, ps_flags_o};
    endfunction
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        rdc(mdt_pkg::REG_CTRL, 32'h0);
        rdc(mdt_pkg::REG_STATUS, 32'h0);
        rdc(mdt_pkg::REG_WORD2, 32'h0);
        rdc(mdt_pkg::REG_COUNT, 32'h0);
        apb(1'b1, 12'h010, 32'h3);
        chk("slverr", {31'h0, er_v}, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", rd_v, 32'h0);
        rdc(mdt_pkg::REG_CTRL, 32'h0);
    endtask
    task automatic t_ext();
        rx_dir_i <= 1'b1;
        run(32'h8028_0008, 32'h825a_7123, 5'd12);
        kchk(48'h8866_5554_3210, 12);
        chk("dec", dec(), 32'h425a);
        chk("mask", masks[2], 32'hffff_0000);
        chk("mask", masks[3], 32'h0);
        chk("mask", masks[4], 32'h0);
        chk("mask", masks[10], 32'hffff_ffff);
        chk("data", dats[6], 32'hd000_0006);
        chk("data", dats[10], 32'hd000_000a);
        rdc(mdt_pkg::REG_WORD2, 32'h825a_7123);
        ret(32'h7123);
        rx_dir_i <= 1'b0;
    endtask
    task automatic t_plain();
        apb(1'b1, mdt_pkg::REG_CTRL, 32'h2);
        run(32'h8010_0004, 32'h0100_1abc, 5'd5);
        kchk(48'h8_6210, 5);
        chk("dec", dec(), 32'h0100);
        chk("data", dats[4], 32'h0400_00d0);
        chk("data", dats[3], 32'hd000_0003);
        chk("mask", masks[4], 32'h0);
        rdc(mdt_pkg::REG_STATUS, 32'h0);
        ret(32'h1abc);
    endtask
    task automatic t_bad();
        run(32'h4000_0000, 32'h2800_0000, 5'd4);
        rdc(mdt_pkg::REG_STATUS, 32'h7);
        apb(1'b1, mdt_pkg::REG_STATUS, 32'h7);
        rdc(mdt_pkg::REG_STATUS, 32'h0);
        rdc(mdt_pkg::REG_COUNT, 32'h3);
    endtask
    task automatic summarize();
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        t_regs();
        t_ext();
        t_plain();
        t_bad();
        summarize();
    end
endmodule
`default_nettype wire
